// *** pkg/shaping_pkg.sv ***
package shaping_pkg;

  // Register byte offsets (printed offsets are not multiples of four: index * 4)
  localparam logic [7:0]  IDX_DIVIDER_LOW   = 8'h1D;
  localparam logic [7:0]  IDX_CONFIG        = 8'h1E;
  localparam logic [7:0]  IDX_DEVIATION     = 8'h1C;
  localparam logic [9:0]  ADDR_DIVIDER_LOW  = {IDX_DIVIDER_LOW, 2'b00};
  localparam logic [9:0]  ADDR_CONFIG       = {IDX_CONFIG, 2'b00};
  localparam logic [9:0]  ADDR_DEVIATION    = {IDX_DEVIATION, 2'b00};

  // Reset values
  localparam logic [7:0]  RST_DIVIDER_LOW   = 8'h08;
  localparam logic [7:0]  RST_CONFIG        = 8'h78;
  localparam logic [7:0]  RST_DEVIATION     = 8'hDF;

  // Config and deviation field positions
  localparam int          POS_DIV_HI_LSB    = 0;
  localparam int          POS_DIV_HI_MSB    = 2;
  localparam int          POS_BYPASS        = 3;
  localparam int          POS_RSVD_LSB      = 4;
  localparam int          POS_RSVD_MSB      = 6;
  localparam int          POS_HOP_SKIP      = 7;
  localparam int          POS_DEV_MSB       = 4;

  localparam int          DIV_WIDTH         = 11;
  localparam int          DEV_WIDTH         = 5;
  localparam int          RECOMMENDED_NGF   = 16;

endpackage : shaping_pkg

// *** design/gaussian_filter_clock_config.sv ***
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Eleven-bit divider; low eight bits fill the whole divider-low register.
// - Divider bits ten to eight come from config bits two to zero.
// - Filter samples at crystal clock divided by divider plus one.
// - Config bit three set bypasses the filter; clear keeps it active.
// - Config bit seven set skips VCO calibration for hops below 1 MHz.
// - Filter output samples are multiplied by the 5-bit deviation value.
module gaussian_filter_clock_config
  import shaping_pkg::*;
#(
  parameter int SAMPLE_WIDTH = 12
) (
  // APB slave
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [11:0]                       paddr,
  input  wire logic [31:0]                       pwdata,
  input  wire logic [3:0]                        pstrb,
  output logic      [31:0]                       prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  // Shaping datapath
  input  wire logic signed [SAMPLE_WIDTH-1:0]    filter_sample,
  input  wire logic signed [SAMPLE_WIDTH-1:0]    raw_sample,
  output logic                                   sample_en,
  output logic                                   shaping_bypass,
  output logic signed [SAMPLE_WIDTH+DEV_WIDTH:0] shaped_out,
  // Synthesizer control
  output logic                                   hop_cal_skip
);

  // Product must fit the scaler output and stay a real signed sample
  if (SAMPLE_WIDTH < 2 || SAMPLE_WIDTH > 24) begin : g_bad_width
    $error("SAMPLE_WIDTH out of range");
  end

  logic [7:0]           div_low_q;
  logic [7:0]           config_q;
  logic [7:0]           deviation_q;
  logic [DIV_WIDTH-1:0] divider;
  logic [DIV_WIDTH-1:0] count_q;
  logic                 sample_en_q;
  logic                 access;
  logic                 hit;
  logic [31:0]          rdata;

  assign access  = psel && penable;
  assign pready  = 1'b1;
  assign hit     = (paddr[11:10] == 2'b00) && ((paddr[9:0] == ADDR_DIVIDER_LOW) ||
                   (paddr[9:0] == ADDR_CONFIG) || (paddr[9:0] == ADDR_DEVIATION));
  assign pslverr = access && !hit;

  // Writes take effect only on the completing edge; byte lane 0 carries the register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_low_q   <= RST_DIVIDER_LOW;
      config_q    <= RST_CONFIG;
      deviation_q <= RST_DEVIATION;
    end else if (access && pwrite && pstrb[0]) begin
      case (paddr)
        {2'b00, ADDR_DIVIDER_LOW}: div_low_q   <= pwdata[7:0];
        {2'b00, ADDR_CONFIG}:      config_q    <= pwdata[7:0];
        {2'b00, ADDR_DEVIATION}:   deviation_q <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Reserved bits are stored as written; software is expected to keep them set
  always_comb begin
    rdata = 32'h0000_0000;
    case (paddr)
      {2'b00, ADDR_DIVIDER_LOW}: rdata[7:0] = div_low_q;
      {2'b00, ADDR_CONFIG}:      rdata[7:0] = config_q;
      {2'b00, ADDR_DEVIATION}:   rdata[7:0] = deviation_q;
      default:                   rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdata;
    end
  end

  assign divider = {config_q[POS_DIV_HI_MSB:POS_DIV_HI_LSB], div_low_q};

  // Count down from the divider; reload is picked up at wrap so a new value
  // never truncates the sample in flight.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q     <= '0;
      sample_en_q <= 1'b0;
    end else if (count_q == '0) begin
      count_q     <= divider;
      sample_en_q <= 1'b1;
    end else begin
      count_q     <= count_q - 1'b1;
      sample_en_q <= 1'b0;
    end
  end

  assign sample_en      = sample_en_q;
  assign shaping_bypass = config_q[POS_BYPASS];
  assign hop_cal_skip   = config_q[POS_HOP_SKIP];

  // Bypass feeds the unfiltered sample to the scaler
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shaped_out <= '0;
    end else if (sample_en_q) begin
      shaped_out <= (config_q[POS_BYPASS] ? raw_sample : filter_sample) *
                    $signed({1'b0, deviation_q[POS_DEV_MSB:0]});
    end
  end

  // Helper: cycles since last sample enable
  logic [DIV_WIDTH:0] gap_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q <= '0;
    end else if (sample_en_q) begin
      gap_q <= '0;
    end else begin
      gap_q <= gap_q + 1'b1;
    end
  end

  // Helper: divider in force for the running period, and first pulse seen
  logic [DIV_WIDTH-1:0] span_q;
  logic                 seen_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      span_q <= '0;
    end else if (count_q == '0) begin
      span_q <= divider;
    end
  end

  // First pulse after reset has no full period behind it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_q <= 1'b0;
    end else if (sample_en_q) begin
      seen_q <= 1'b1;
    end
  end

  chk_enable_spacing: assert property (@(posedge pclk) disable iff (!presetn)
    sample_en_q && seen_q
    |-> gap_q == {1'b0, $past(span_q)})
    else $error("sample spacing");
  chk_reload_value: assert property (@(posedge pclk) disable iff (!presetn)
    sample_en_q |-> count_q == $past(divider)) else $error("counter reload wrong");
  chk_divider_concat: assert property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && pstrb[0] && paddr == {2'b00, ADDR_CONFIG}
    |=> divider[DIV_WIDTH-1:8] == $past(pwdata[POS_DIV_HI_MSB:POS_DIV_HI_LSB]))
    else $error("divider high bits");
  chk_low_write: assert property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && pstrb[0] && paddr == {2'b00, ADDR_DIVIDER_LOW}
    |=> div_low_q == $past(pwdata[7:0])) else $error("divider low write lost");
  chk_bypass_out: assert property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && pstrb[0] && paddr == {2'b00, ADDR_CONFIG}
    |=> shaping_bypass == $past(pwdata[POS_BYPASS]))
    else $error("bypass mismatch");
  chk_hop_skip: assert property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && pstrb[0] && paddr == {2'b00, ADDR_CONFIG}
    |=> hop_cal_skip == $past(pwdata[POS_HOP_SKIP])) else $error("hop skip not updated");
  chk_scaled_sample: assert property (@(posedge pclk) disable iff (!presetn)
    sample_en_q && !config_q[POS_BYPASS] && $stable(deviation_q)
    |=> shaped_out == $past(filter_sample) * $signed({1'b0, $past(deviation_q[POS_DEV_MSB:0])}))
    else $error("deviation product wrong");
  chk_period_exact: assert property (@(posedge pclk) disable iff (!presetn)
    sample_en_q ##1 (!sample_en_q && $stable(divider))[*1] |-> count_q == $past(divider, 2) - 1'b1)
    else $error("countdown wrong");
  chk_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    access && !hit |-> pslverr) else $error("unmapped address not flagged");

  chk_unmapped_wr: assert property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && !hit
    |=> $stable(div_low_q) && $stable(config_q) && $stable(deviation_q))
    else $error("unmapped write changed a register");

  chk_strobe_gate: assert property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && !pstrb[0]
    |=> $stable(div_low_q) && $stable(config_q) && $stable(deviation_q))
    else $error("write without strobe landed");

  chk_idle_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(access && pwrite)
    |=> $stable(div_low_q) && $stable(config_q) && $stable(deviation_q))
    else $error("register changed without write");

  chk_read_config: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && paddr == {2'b00, ADDR_CONFIG}
    |=> prdata == {24'h000000, $past(config_q)})
    else $error("config read data wrong");

  chk_read_low: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && paddr == {2'b00, ADDR_DIVIDER_LOW}
    |=> prdata == {24'h000000, $past(div_low_q)})
    else $error("divider low read data wrong");

  chk_prdata_upper: assert property (@(posedge pclk) disable iff (!presetn)
    prdata[31:8] == 24'h000000)
    else $error("read data upper bits set");

  chk_ready_high: assert property (@(posedge pclk) disable iff (!presetn)
    access |-> pready)
    else $error("wait state inserted");

  chk_mapped_ok: assert property (@(posedge pclk) disable iff (!presetn)
    access && hit |-> !pslverr)
    else $error("mapped address flagged");

  chk_err_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !access |-> !pslverr)
    else $error("error outside access phase");

  chk_shaped_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !sample_en_q |=> $stable(shaped_out))
    else $error("output moved between samples");

  chk_bypass_sample: assert property (@(posedge pclk) disable iff (!presetn)
    sample_en_q && config_q[POS_BYPASS]
    |=> shaped_out == $past(raw_sample) * $signed({1'b0, $past(deviation_q[POS_DEV_MSB:0])}))
    else $error("bypass product wrong");

  chk_pulse_single: assert property (@(posedge pclk) disable iff (!presetn)
    sample_en_q && count_q != '0
    |=> !sample_en_q)
    else $error("pulse longer than one cycle");

  chk_wrap_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    count_q == '0
    |=> sample_en_q)
    else $error("no pulse at wrap");

  chk_count_step: assert property (@(posedge pclk) disable iff (!presetn)
    count_q != '0
    |=> count_q == $past(count_q) - 1'b1)
    else $error("counter did not step");

  chk_hop_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(access && pwrite && pstrb[0] && paddr == {2'b00, ADDR_CONFIG})
    |=> $stable(hop_cal_skip))
    else $error("hop skip moved without write");

  chk_dev_write: assert property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && pstrb[0] && paddr == {2'b00, ADDR_DEVIATION}
    |=> deviation_q == $past(pwdata[7:0]))
    else $error("deviation write lost");

  chk_rsvd_kept: assert property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && pstrb[0] && paddr == {2'b00, ADDR_CONFIG}
    |=> config_q[POS_RSVD_MSB:POS_RSVD_LSB] == $past(pwdata[POS_RSVD_MSB:POS_RSVD_LSB]))
    else $error("reserved bits not stored");

  chk_low_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(access && pwrite && pstrb[0] && paddr == {2'b00, ADDR_DIVIDER_LOW})
    |=> $stable(div_low_q))
    else $error("divider low moved without write");

  chk_dev_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(access && pwrite && pstrb[0] && paddr == {2'b00, ADDR_DEVIATION})
    |=> $stable(deviation_q))
    else $error("deviation moved without write");

  cov_divider_write: cover property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && paddr == {2'b00, ADDR_DIVIDER_LOW});
  cov_bypass_on: cover property (@(posedge pclk) disable iff (!presetn) $rose(shaping_bypass));
  cov_hop_skip_on: cover property (@(posedge pclk) disable iff (!presetn) $rose(hop_cal_skip));
  cov_sample_pair: cover property (@(posedge pclk) disable iff (!presetn) sample_en ##[1:40] sample_en);
  cov_unmapped_access: cover property (@(posedge pclk) disable iff (!presetn) access && !hit);

endmodule : gaussian_filter_clock_config

`default_nettype wire

// *** dv/gaussian_filter_clock_config_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module gaussian_filter_clock_config_tb;
  import shaping_pkg::*;
  logic               pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0]        paddr = '0;
  logic [31:0]        pwdata = '0, prdata, rd;
  logic [3:0]         pstrb = 4'hF;
  logic               pready, pslverr, err, sample_en, shaping_bypass, hop_cal_skip;
  logic signed [11:0] filter_sample = -12'sd7, raw_sample = 12'sd100;
  logic signed [17:0] shaped_out;
  int                 n_mismatch = 0, n_checks = 0, cyc = 0, c;
  always #5 pclk = ~pclk;
  gaussian_filter_clock_config #(.SAMPLE_WIDTH(12)) u_gaussian_filter_clock_config (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .filter_sample(filter_sample), .raw_sample(raw_sample),
    .sample_en(sample_en), .shaping_bypass(shaping_bypass), .shaped_out(shaped_out),
    .hop_cal_skip(hop_cal_skip));
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // Holds the request until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= {2'b00, a}; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic wait_en();
    c = 0;
    do begin @(posedge pclk); c++; end while (sample_en !== 1'b1 && c < 3000);
  endtask : wait_en
  task automatic t_reset();
    check("bypass", 32'(shaping_bypass), 32'h1);
    check("hopskip", 32'(hop_cal_skip), 32'h0);
    apb(1'b0, ADDR_DIVIDER_LOW, 32'h0);
    check("div_low", rd, 32'h08);
    apb(1'b0, ADDR_CONFIG, 32'h0);
    check("config", rd, 32'h78);
    wait_en(); wait_en();
    check("period", 32'(c), 32'd9);
  endtask : t_reset
  task automatic t_divider();
    apb(1'b1, ADDR_DIVIDER_LOW, 32'h02);
    apb(1'b1, ADDR_CONFIG, 32'h71);
    // New value only loads at the next wrap
    wait_en(); wait_en(); wait_en();
    check("period_hi", 32'(c), 32'd259);
    apb(1'b1, ADDR_DIVIDER_LOW, 32'hFF);
    apb(1'b1, ADDR_CONFIG, 32'h70);
    wait_en(); wait_en(); wait_en();
    check("period_lo", 32'(c), 32'd256);
    apb(1'b0, ADDR_DIVIDER_LOW, 32'h0);
    check("div_rb", rd, 32'hFF);
  endtask : t_divider
  task automatic t_shape();
    apb(1'b1, ADDR_DEVIATION, 32'hFF);
    apb(1'b1, ADDR_DIVIDER_LOW, 32'h03);
    wait_en(); wait_en();
    @(posedge pclk);
    check("filtered", 32'(shaped_out), 32'(-217));
    apb(1'b1, ADDR_CONFIG, 32'hF8);
    @(posedge pclk);
    check("bypass_on", 32'(shaping_bypass), 32'h1);
    check("hopskip_on", 32'(hop_cal_skip), 32'h1);
    wait_en(); wait_en();
    @(posedge pclk);
    check("bypassed", 32'(shaped_out), 32'd3100);
  endtask : t_shape
  task automatic t_refuse();
    apb(1'b0, 10'h07C, 32'h0);
    check("unmap_err", 32'(err), 32'h1);
    check("unmap_rd", rd, 32'h0);
    pstrb <= 4'h0;
    apb(1'b1, ADDR_DIVIDER_LOW, 32'h55);
    pstrb <= 4'hF;
    apb(1'b0, ADDR_DIVIDER_LOW, 32'h0);
    check("strb_off", rd, 32'h03);
  endtask : t_refuse
  task automatic test_done();
    if (n_mismatch == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  // Whole run needs about 1600 cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 6000) begin
      n_mismatch++;
      test_done();
    end
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_divider();
    t_shape();
    t_refuse();
    test_done();
  end
endmodule : gaussian_filter_clock_config_tb
`default_nettype wire
